/* File: rtl/mbx_pkg.sv */
// constants for the travel-limit and auxiliary i/o block
package mbx_pkg;
  // ----------------------------------------------------------------
  // command frames
  // ----------------------------------------------------------------
  localparam logic [31:0] CMD_BORDER     = 32'h73646573;
  localparam logic [31:0] CMD_AUX_IO     = 32'h6F696573;
  localparam logic [4:0]  LEN_BORDER     = 5'h1A;
  localparam logic [4:0]  LEN_AUX_IO     = 5'h12;
  localparam logic [4:0]  LEN_HEAD       = 5'h04;
  localparam int          FRAME_MAX      = 26;
  // byte offsets inside a frame, little endian
  localparam int          OFS_FLAGS_A    = 4;
  localparam int          OFS_FLAGS_B    = 5;
  localparam int          OFS_LEFT_STEP  = 6;
  localparam int          OFS_LEFT_FRAC  = 10;
  localparam int          OFS_RIGHT_STEP = 12;
  localparam int          OFS_RIGHT_FRAC = 16;
  // ----------------------------------------------------------------
  // flag bits
  // ----------------------------------------------------------------
  localparam int          BIT_FROM_POS   = 0;
  localparam int          BIT_STOP_LEFT  = 1;
  localparam int          BIT_STOP_RIGHT = 2;
  localparam int          BIT_EITHER     = 3;
  localparam int          BIT_SW_SWAP    = 0;
  localparam int          BIT_ONE_LOW    = 1;
  localparam int          BIT_TWO_LOW    = 2;
  localparam int          BIT_DRIVE_OUT  = 0;
  localparam int          BIT_INVERT     = 1;
  // ----------------------------------------------------------------
  // auxiliary i/o codes
  // ----------------------------------------------------------------
  localparam logic [3:0]  IN_NONE        = 4'h0;
  localparam logic [3:0]  IN_STOP        = 4'h1;
  localparam logic [3:0]  IN_POWER_OFF   = 4'h2;
  localparam logic [3:0]  IN_REL_MOVE    = 4'h3;
  localparam logic [3:0]  IN_HOME        = 4'h4;
  localparam logic [3:0]  IN_ALARM       = 4'h5;
  localparam logic [3:0]  OUT_OFF        = 4'h0;
  localparam logic [3:0]  OUT_ON         = 4'h1;
  localparam logic [3:0]  OUT_MOVING     = 4'h2;
  localparam logic [3:0]  OUT_ALARM      = 4'h3;
  localparam logic [3:0]  OUT_POWERED    = 4'h4;
  localparam logic signed [15:0] FRAC_MAX = 16'sh00FF;
  localparam logic signed [15:0] FRAC_MIN = -16'sh00FF;
  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_FRAME_BYTE  = 4'h0;
  localparam logic [3:0]  ADDR_FRAME_ABORT = 4'h1;
  localparam logic [3:0]  ADDR_STATUS      = 4'h2;
  localparam logic [3:0]  ADDR_ANSWER      = 4'h3;
  localparam logic [3:0]  ADDR_CONFIG      = 4'h4;
  localparam logic [3:0]  ADDR_LEFT        = 4'h5;
  localparam logic [3:0]  ADDR_RIGHT       = 4'h6;
  typedef enum logic [2:0] {
    MBX_HEAD = 3'b001,
    MBX_BODY = 3'b010,
    MBX_SKIP = 3'b100
  } mbx_rx_state_t;
endpackage

/* File: rtl/mbx_frame_rx.sv */
// command frame assembler for the travel-limit and auxiliary i/o block
`timescale 1ns/1ps
module mbx_frame_rx
  import mbx_pkg::*;
(
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       srst,
  // byte stream
  input  wire logic                       byte_valid,
  input  wire logic [7:0]                 byte_data,
  input  wire logic                       abort,
  // assembled frame
  output logic                            frame_done,
  output logic                            frame_is_border,
  output logic                            busy,
  output logic [8*FRAME_MAX-1:0]          frame_buf
);
  mbx_rx_state_t          state;
  mbx_rx_state_t          next_state;
  logic [4:0]             count;
  logic [4:0]             next_count;
  logic [4:0]             length;
  logic [4:0]             next_length;
  logic                   next_done;
  logic                   next_is_border;
  logic [8*FRAME_MAX-1:0] next_buf;
  logic [31:0]            head;

  // ----------------------------------------------------------------
  // byte collection
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state     = state;
    next_count     = count;
    next_length    = length;
    next_done      = 1'b0;
    next_is_border = frame_is_border;
    next_buf       = frame_buf;
    head           = {byte_data, frame_buf[23:0]};
    if (abort)
    begin
      next_state = MBX_HEAD;
      next_count = '0;
    end
    else if (byte_valid)
    begin
      unique case (state)
        MBX_HEAD:
        begin
          next_buf[8*count +: 8] = byte_data;
          next_count             = count + 5'h01;
          if (count == LEN_HEAD - 5'h01)
          begin
            // unknown codes are dropped until the host aborts
            if (head == CMD_BORDER)
            begin
              next_state     = MBX_BODY;
              next_length    = LEN_BORDER;
              next_is_border = 1'b1;
            end
            else if (head == CMD_AUX_IO)
            begin
              next_state     = MBX_BODY;
              next_length    = LEN_AUX_IO;
              next_is_border = 1'b0;
            end
            else
              next_state = MBX_SKIP;
          end
        end
        MBX_BODY:
        begin
          next_buf[8*count +: 8] = byte_data;
          next_count             = count + 5'h01;
          if (count == length - 5'h01) // R23
          begin
            next_done  = 1'b1;
            next_state = MBX_HEAD;
            next_count = '0;
          end
        end
        MBX_SKIP:
          next_state = MBX_SKIP;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state           <= MBX_HEAD;
      count           <= '0;
      length          <= LEN_HEAD;
      frame_done      <= 1'b0;
      frame_is_border <= 1'b0;
      frame_buf       <= '0;
    end
    else
    begin
      state           <= next_state;
      count           <= next_count;
      length          <= next_length;
      frame_done      <= next_done;
      frame_is_border <= next_is_border;
      frame_buf       <= next_buf;
    end
  end

  assign busy = (state != MBX_HEAD) || (count != '0);
endmodule

/* File: rtl/mbx_limit_io.sv */
// travel-limit and auxiliary i/o logic of the motion controller
//
// Summary of operation
// R01: flag bit 0x1 picks stored positions as borders, else limit switches.
// R02: flag bit 0x2 halts motion on reaching the left border.
// R03: flag bit 0x4 halts motion on reaching the right border.
// R04: flag bit 0x8 halts motion at either border, guarding misconfiguration.
// R05: switch bit 0x1 makes the first switch the right one.
// R06: switch bit 0x2 makes a low first switch pin the triggered state.
// R07: switch bit 0x4 makes a low second switch pin the triggered state.
// R08: borders are signed 32-bit steps, compared only in position mode.
// R09: each border has a signed 1/256 fraction, clamped to magnitude 255.
// R10: setup bit 0x1 drives the aux pin out, else it is sampled.
// R11: setup bit 0x2 inverts: falling edge event, low level active.
// R12: without inversion rising edges are events and high is active.
// R13: low mode nibble picks the input action; zero does nothing.
// R14: action 1 stops the motor, action 2 powers windings off.
// R15: action 3 starts a relative move, action 4 starts homing.
// R16: action 5 enters the alarm state.
// R17: high mode nibble 0 holds pin inactive, 1 holds it active.
// R18: output code 2 is active while the motor moves.
// R19: output code 3 is active while the alarm state lasts.
// R20: output code 4 is active while windings are powered.
// R21: aux i/o frame is 18 bytes under its code; answer is the code.
// R22: border frame code is recognised as the border settings command.
// R23: reserved bytes ignored; settings apply only after a whole frame.
`timescale 1ns/1ps
module mbx_limit_io
  import mbx_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               srst,
  // register port
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_write,
  input  wire logic               reg_read,
  output logic [31:0]             reg_rdata,
  // motion engine state
  input  wire logic signed [31:0] position_steps,
  input  wire logic signed [15:0] position_fraction,
  input  wire logic               motor_moving,
  input  wire logic               moving_left,
  input  wire logic               moving_right,
  input  wire logic               windings_powered,
  input  wire logic               alarm_clear,
  // limit switches
  input  wire logic               switch_one_pin,
  input  wire logic               switch_two_pin,
  // auxiliary pin
  input  wire logic               aux_io_in,
  output logic                    aux_io_out,
  output logic                    aux_io_oe,
  // requests to the motion engine
  output logic                    halt_request,
  output logic                    at_left_limit,
  output logic                    at_right_limit,
  output logic                    motion_stop,
  output logic                    windings_power_off,
  output logic                    relative_move,
  output logic                    home_start,
  output logic                    alarm_state
);
  // ----------------------------------------------------------------
  // frame reception
  // ----------------------------------------------------------------
  logic                   frame_done;
  logic                   frame_is_border;
  logic                   rx_busy;
  logic [8*FRAME_MAX-1:0] frame_buf;

  mbx_frame_rx u_rx (
    .clock           (clock),
    .srst            (srst),
    .byte_valid      (reg_write && reg_addr == ADDR_FRAME_BYTE),
    .byte_data       (reg_wdata[7:0]),
    .abort           (reg_write && reg_addr == ADDR_FRAME_ABORT),
    .frame_done      (frame_done),
    .frame_is_border (frame_is_border),
    .busy            (rx_busy),
    .frame_buf       (frame_buf)
  );

  function automatic logic signed [15:0] clamp_frac(input logic signed [15:0] v);
    if (v > FRAC_MAX)
      clamp_frac = FRAC_MAX;
    else if (v < FRAC_MIN)
      clamp_frac = FRAC_MIN;
    else
      clamp_frac = v;
  endfunction

  // ----------------------------------------------------------------
  // settings
  // ----------------------------------------------------------------
  logic [7:0]         travel_limit_flags;
  logic [7:0]         limit_switch_flags;
  logic signed [31:0] left_limit_steps;
  logic signed [15:0] left_limit_fraction;
  logic signed [31:0] right_limit_steps;
  logic signed [15:0] right_limit_fraction;
  logic [7:0]         aux_io_setup_flags;
  logic [7:0]         aux_io_action_select;
  logic [31:0]        answer_code;
  logic               answer_ready;
  logic [7:0]         next_travel_flags;
  logic [7:0]         next_switch_flags;
  logic signed [31:0] next_left_steps;
  logic signed [15:0] next_left_frac;
  logic signed [31:0] next_right_steps;
  logic signed [15:0] next_right_frac;
  logic [7:0]         next_setup_flags;
  logic [7:0]         next_action_select;
  logic [31:0]        next_answer_code;
  logic               next_answer_ready;
  logic               answer_read;

  assign answer_read = reg_read && reg_addr == ADDR_ANSWER;

  always_comb
  begin
    next_travel_flags  = travel_limit_flags;
    next_switch_flags  = limit_switch_flags;
    next_left_steps    = left_limit_steps;
    next_left_frac     = left_limit_fraction;
    next_right_steps   = right_limit_steps;
    next_right_frac    = right_limit_fraction;
    next_setup_flags   = aux_io_setup_flags;
    next_action_select = aux_io_action_select;
    next_answer_code   = answer_code;
    next_answer_ready  = answer_ready && !answer_read;
    // no setting changes until the last byte of a frame is in; answer_ready still clears on an answer read
    if (frame_done) // R23
    begin
      next_answer_ready = 1'b1;
      if (frame_is_border) // R22
      begin
        next_answer_code  = CMD_BORDER;
        next_travel_flags = frame_buf[8*OFS_FLAGS_A +: 8];
        next_switch_flags = frame_buf[8*OFS_FLAGS_B +: 8];
        next_left_steps   = frame_buf[8*OFS_LEFT_STEP +: 32]; // R08
        next_right_steps  = frame_buf[8*OFS_RIGHT_STEP +: 32];
        next_left_frac    = clamp_frac(frame_buf[8*OFS_LEFT_FRAC +: 16]); // R09
        next_right_frac   = clamp_frac(frame_buf[8*OFS_RIGHT_FRAC +: 16]);
      end
      else
      begin
        next_answer_code   = CMD_AUX_IO; // R21
        next_setup_flags   = frame_buf[8*OFS_FLAGS_A +: 8];
        next_action_select = frame_buf[8*OFS_FLAGS_B +: 8];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      travel_limit_flags   <= '0;
      limit_switch_flags   <= '0;
      left_limit_steps     <= '0;
      left_limit_fraction  <= '0;
      right_limit_steps    <= '0;
      right_limit_fraction <= '0;
      aux_io_setup_flags   <= '0;
      aux_io_action_select <= '0;
      answer_code          <= '0;
      answer_ready         <= 1'b0;
    end
    else
    begin
      travel_limit_flags   <= next_travel_flags;
      limit_switch_flags   <= next_switch_flags;
      left_limit_steps     <= next_left_steps;
      left_limit_fraction  <= next_left_frac;
      right_limit_steps    <= next_right_steps;
      right_limit_fraction <= next_right_frac;
      aux_io_setup_flags   <= next_setup_flags;
      aux_io_action_select <= next_action_select;
      answer_code          <= next_answer_code;
      answer_ready         <= next_answer_ready;
    end
  end

  // ----------------------------------------------------------------
  // travel limits
  // ----------------------------------------------------------------
  logic               limit_from_position;
  logic               halt_at_either_limit;
  logic               switch_one_hit;
  logic               switch_two_hit;
  logic signed [39:0] pos_fine;
  logic signed [39:0] left_fine;
  logic signed [39:0] right_fine;
  logic               left_reached;
  logic               right_reached;
  logic               next_halt;

  assign limit_from_position  = travel_limit_flags[BIT_FROM_POS];
  assign halt_at_either_limit = travel_limit_flags[BIT_EITHER];

  always_comb
  begin
    // switch pins are already synchronous to clock
    switch_one_hit = switch_one_pin ^ limit_switch_flags[BIT_ONE_LOW]; // R06
    switch_two_hit = switch_two_pin ^ limit_switch_flags[BIT_TWO_LOW]; // R07
    pos_fine       = $signed({position_steps, 8'h00}) + 40'(position_fraction);
    left_fine      = $signed({left_limit_steps, 8'h00}) + 40'(left_limit_fraction);
    right_fine     = $signed({right_limit_steps, 8'h00}) + 40'(right_limit_fraction);
    if (limit_from_position) // R01
    begin
      left_reached  = pos_fine <= left_fine; // R08
      right_reached = pos_fine >= right_fine;
    end
    else if (limit_switch_flags[BIT_SW_SWAP]) // R05
    begin
      left_reached  = switch_two_hit;
      right_reached = switch_one_hit;
    end
    else
    begin
      left_reached  = switch_one_hit;
      right_reached = switch_two_hit;
    end
    next_halt = (left_reached && travel_limit_flags[BIT_STOP_LEFT] && moving_left)    // R02
             || (right_reached && travel_limit_flags[BIT_STOP_RIGHT] && moving_right) // R03
             || ((left_reached || right_reached) && halt_at_either_limit
                 && motor_moving); // R04
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      halt_request   <= 1'b0;
      at_left_limit  <= 1'b0;
      at_right_limit <= 1'b0;
    end
    else
    begin
      halt_request   <= next_halt;
      at_left_limit  <= left_reached;
      at_right_limit <= right_reached;
    end
  end

  // ----------------------------------------------------------------
  // auxiliary pin
  // ----------------------------------------------------------------
  logic       aux_io_drive_out;
  logic       aux_io_invert;
  logic [3:0] aux_in_action_field;
  logic [3:0] aux_out_behaviour_field;
  logic       in_level;
  logic       prev_level;
  logic       in_event;
  logic       out_active;
  logic       next_stop;
  logic       next_power_off;
  logic       next_rel_move;
  logic       next_home;
  logic       next_alarm;
  logic       next_out;

  assign aux_io_drive_out        = aux_io_setup_flags[BIT_DRIVE_OUT];
  assign aux_io_invert           = aux_io_setup_flags[BIT_INVERT];
  assign aux_in_action_field     = aux_io_action_select[3:0];
  assign aux_out_behaviour_field = aux_io_action_select[7:4];

  always_comb
  begin
    in_level       = aux_io_in ^ aux_io_invert; // R11 R12
    in_event       = !aux_io_drive_out && in_level && !prev_level; // R10
    next_stop      = in_event && aux_in_action_field == IN_STOP; // R13 R14
    next_power_off = in_event && aux_in_action_field == IN_POWER_OFF; // R14
    next_rel_move  = in_event && aux_in_action_field == IN_REL_MOVE; // R15
    next_home      = in_event && aux_in_action_field == IN_HOME; // R15
    // a new alarm event beats a clear in the same cycle
    next_alarm     = (in_event && aux_in_action_field == IN_ALARM) // R16
                  || (alarm_state && !alarm_clear);
    unique case (aux_out_behaviour_field)
      OUT_ON:      out_active = 1'b1; // R17
      OUT_MOVING:  out_active = motor_moving; // R18
      OUT_ALARM:   out_active = alarm_state; // R19
      OUT_POWERED: out_active = windings_powered; // R20
      default:     out_active = 1'b0; // R17
    endcase
    next_out = out_active ^ aux_io_invert; // R11 R12
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      prev_level         <= 1'b0;
      motion_stop        <= 1'b0;
      windings_power_off <= 1'b0;
      relative_move      <= 1'b0;
      home_start         <= 1'b0;
      alarm_state        <= 1'b0;
      aux_io_out         <= 1'b0;
      aux_io_oe          <= 1'b0;
    end
    else
    begin
      prev_level         <= in_level;
      motion_stop        <= next_stop;
      windings_power_off <= next_power_off;
      relative_move      <= next_rel_move;
      home_start         <= next_home;
      alarm_state        <= next_alarm;
      aux_io_out         <= next_out;
      aux_io_oe          <= aux_io_drive_out; // R10
    end
  end

  // ----------------------------------------------------------------
  // register reads
  // ----------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = '0;
    if (reg_read)
    begin
      unique case (reg_addr)
        ADDR_STATUS:
          next_rdata = {24'h000000, rx_busy, answer_ready, aux_io_in, alarm_state,
                        halt_request, at_right_limit, at_left_limit, motor_moving};
        ADDR_ANSWER: next_rdata = answer_code;
        ADDR_CONFIG:
          next_rdata = {aux_io_action_select, aux_io_setup_flags,
                        limit_switch_flags, travel_limit_flags};
        ADDR_LEFT:   next_rdata = left_limit_steps;
        ADDR_RIGHT:  next_rdata = right_limit_steps;
        default:     next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      reg_rdata <= '0;
    else
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  chk_pin_direction: assert property ( // R10
    aux_io_drive_out |=> aux_io_oe ##1 (aux_io_oe || !$past(aux_io_drive_out)))
    else $error("aux pin enable does not follow setup");
  chk_out_always_on: assert property ( // R17
    (aux_out_behaviour_field == OUT_ON && !aux_io_invert && $stable(aux_io_setup_flags))
      |=> aux_io_out)
    else $error("aux pin not active in always-on mode");
  chk_out_moving: assert property ( // R18
    (aux_out_behaviour_field == OUT_MOVING && aux_io_invert && motor_moving)
      |=> !aux_io_out)
    else $error("inverted moving output not low");
  chk_input_stop: assert property ( // R14
    (!aux_io_drive_out && aux_in_action_field == IN_STOP && !aux_io_invert
      && !prev_level && aux_io_in) |=> motion_stop ##1 !motion_stop)
    else $error("stop pulse missing or too long");
  chk_alarm_entry: assert property ( // R16
    (in_event && aux_in_action_field == IN_ALARM) |=> alarm_state)
    else $error("alarm not entered");
  chk_halt_left: assert property ( // R02
    (limit_from_position && travel_limit_flags[BIT_STOP_LEFT] && moving_left
      && position_steps < left_limit_steps) |=> halt_request)
    else $error("no halt at left position border");
  chk_switch_sense: assert property ( // R06
    (!limit_from_position && !limit_switch_flags[BIT_SW_SWAP] && halt_at_either_limit
      && motor_moving && (switch_one_pin != limit_switch_flags[BIT_ONE_LOW]))
      |=> halt_request && at_left_limit)
    else $error("first switch sense wrong");
  chk_apply_on_frame: assert property ( // R23
    !frame_done |=> $stable(aux_io_setup_flags) && $stable(travel_limit_flags))
    else $error("settings changed without a frame");
  chk_frac_range: assert property ( // R09
    left_limit_fraction <= FRAC_MAX && left_limit_fraction >= FRAC_MIN
      && right_limit_fraction <= FRAC_MAX && right_limit_fraction >= FRAC_MIN)
    else $error("border fraction out of range");
  chk_answer_code: assert property ( // R21
    (frame_done && !frame_is_border) |=> answer_code == CMD_AUX_IO && answer_ready)
    else $error("wrong answer code");
endmodule

/* File: verification/mbx_host.sv */
// host model that sends command frames over the register port
`timescale 1ns/1ps
module mbx_host
  import mbx_pkg::*;
(
  // clock
  input  wire logic        clock,
  // register port
  output logic [3:0]       reg_addr,
  output logic [31:0]      reg_wdata,
  output logic             reg_write,
  output logic             reg_read
);
  logic [31:0] exp_q[$];
  initial
  begin
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  task automatic acc(input logic [3:0] a, input logic [31:0] d, input logic rd);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= !rd;
    reg_read <= rd;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_read <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    acc(a, 32'h0, 1'b1);
  endtask
  // whole frame, lowest byte first; settle time covers apply plus output stage
  task automatic frame(input logic [8*FRAME_MAX-1:0] fb, input int n);
    for (int i = 0; i < n; i++)
      acc(ADDR_FRAME_BYTE, {24'h0, fb[8*i+:8]}, 1'b0);
    repeat (4) @(posedge clock);
  endtask
endmodule

/* File: verification/mbx_limit_io_tb.sv */
// self-checking bench for the travel-limit and auxiliary i/o block
`timescale 1ns/1ps
module mbx_limit_io_tb
  import mbx_pkg::*;
;
  logic clock, srst, rdv, aux_io_in, alarm_clear, swa, swb, mov, movl, mright, pwr;
  logic seen_clr = 1'b0;
  logic [3:0] reg_addr, code;
  logic [31:0] reg_wdata, reg_rdata, lft, rgt, seed;
  logic reg_write, reg_read, aux_io_out, aux_io_oe, halt_request, at_l, at_r;
  logic ms, wpo, rmv, hs, alarm_state, inv;
  logic signed [31:0] pos;
  logic [4:0] seen;
  logic [7:0] md;
  logic [8*FRAME_MAX-1:0] fb;
  int bad_count, checks_done;
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  mbx_host host (.clock(clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read));
  mbx_limit_io dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .position_steps(pos), .position_fraction(16'sh0000), .motor_moving(mov),
    .moving_left(movl), .moving_right(mright), .windings_powered(pwr),
    .alarm_clear(alarm_clear), .switch_one_pin(swa), .switch_two_pin(swb),
    .aux_io_in(aux_io_in), .aux_io_out(aux_io_out), .aux_io_oe(aux_io_oe),
    .halt_request(halt_request), .at_left_limit(at_l), .at_right_limit(at_r),
    .motion_stop(ms), .windings_power_off(wpo), .relative_move(rmv), .home_start(hs),
    .alarm_state(alarm_state));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e)
    begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic print_verdict();
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // read data stand only in the cycle after the strobe
  always @(posedge clock)
  begin
    rdv <= reg_read;
    seen <= seen_clr ? 5'h00 : (seen | {alarm_state, hs, rmv, wpo, ms});
  end
  always @(negedge clock)
    if (rdv === 1'b1)
      chk("rdata", reg_rdata, host.exp_q.pop_front());
  // reserved and checksum bytes random: they must not matter
  task automatic mk(input logic [31:0] c, input logic [7:0] a, input logic [7:0] b);
    for (int i = 0; i < FRAME_MAX; i++)
      fb[8*i+:8] = 8'($random(seed));
    fb[47:0] = {b, a, c};
  endtask
  task automatic seio(input logic [7:0] a, input logic [7:0] b);
    mk(CMD_AUX_IO, a, b);
    host.frame(fb, 18);
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    {srst, seed, aux_io_in, alarm_clear, swa, swb, mov, movl, mright, pwr} = {1'b1, 32'h7D4B, 8'h20};
    pos = 32'sh0;
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    host.rd(ADDR_CONFIG, 32'h0);
    host.rd(4'hF, 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      inv = (i == 6);
      code = inv ? IN_STOP : 4'(i);
      aux_io_in <= inv;
      seio({6'h0, inv, 1'b0}, {4'h0, code});
      seen_clr <= 1'b1;
      @(posedge clock);
      seen_clr <= 1'b0;
      aux_io_in <= !inv;
      repeat (4) @(posedge clock);
      chk("action", seen, (32'h1 << code) >> 1);
      chk("oe_in", aux_io_oe, 1'b0);
      if (code == IN_ALARM)
      begin
        seio(8'h01, 8'h30);
        chk("alarm_out", aux_io_out, 1'b1);
      end
      alarm_clear <= 1'b1;
      @(posedge clock);
      alarm_clear <= 1'b0;
      repeat (2) @(posedge clock);
      if (code == IN_ALARM)
        chk("alarm_off", aux_io_out, 1'b0);
    end
    for (int i = 0; i < 8; i++)
    begin
      md = {4'(i % 4 == 3 ? 4 : i % 4), 4'h0};
      inv = (i >= 4);
      {mov, pwr} <= 2'($random(seed));
      seio({6'h0, inv, 1'b1}, md);
      chk("oe_out", aux_io_oe, 1'b1);
      chk("out", aux_io_out, inv ^ (md == 8'h10 | md == 8'h20 & mov | md == 8'h40 & pwr));
    end
    host.rd(ADDR_STATUS, {24'h0, 7'h21, mov});
    host.rd(ADDR_ANSWER, CMD_AUX_IO);
    lft = -32'($random(seed) & 32'hFFFF);
    rgt = 32'($random(seed) & 32'hFFFF);
    mk(CMD_BORDER, 8'h07, 8'h00);
    fb[143:48] = {16'h0, rgt, 16'h0, lft};
    host.frame(fb, 26);
    host.rd(ADDR_LEFT, lft);
    host.rd(ADDR_RIGHT, rgt);
    host.rd(ADDR_ANSWER, CMD_BORDER);
    host.rd(ADDR_CONFIG, {md, 8'h03, 8'h00, 8'h07});
    pos <= rgt + 1;
    mright <= 1'b1;
    repeat (3) @(posedge clock);
    chk("right", {at_r, at_l, halt_request}, 3'b101);
    {mright, movl} <= 2'b01;
    repeat (3) @(posedge clock);
    chk("no_left_halt", halt_request, 1'b0);
    pos <= lft - 1;
    repeat (3) @(posedge clock);
    chk("left", {at_r, at_l, halt_request}, 3'b011);
    mk(CMD_BORDER, 8'h02, 8'h02);
    host.frame(fb, 26);
    swa <= 1'b0;
    repeat (3) @(posedge clock);
    chk("switch_left", {at_r, at_l, halt_request}, 3'b011);
    for (int i = 0; i < 2; i++)
    begin
      mk(CMD_BORDER, 8'h08, 8'(2 + i));
      host.frame(fb, 26);
      mov <= 1'b1;
      movl <= 1'b0;
      repeat (3) @(posedge clock);
      chk("either", {at_r, at_l, halt_request}, i ? 3'b101 : 3'b011);
    end
    print_verdict();
  end
endmodule
